// ---- quad_data_pointer_unit.sv ----
// Quad 24-bit data pointer unit with select, direction, auto-toggle and auto-step
`timescale 1ns/1ns
`include "quad_pointer_defs.svh"
module quad_data_pointer_unit (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input quad_pointer_pkg::sfr_req_type sfr_req_in,
  input quad_pointer_pkg::instr_strobe_type instr_in,
  input wire logic [23:0] load_data_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  output logic [23:0] active_ptr_out,
  output logic [1:0] active_index_out
);

  // Which pointer a byte address belongs to
  function automatic logic [1:0] slot_of(input logic [7:0] addr);
    logic [1:0] idx;
    idx = 2'h0;
    unique case (addr)
      `ADDR_PTR1_HIGH, `ADDR_PTR1_MID, `ADDR_PTR1_LOW: idx = 2'h1;
      `ADDR_PTR2_HIGH, `ADDR_PTR2_MID, `ADDR_PTR2_LOW: idx = 2'h2;
      `ADDR_PTR3_HIGH, `ADDR_PTR3_MID, `ADDR_PTR3_LOW: idx = 2'h3;
      default: idx = 2'h0;
    endcase
    return idx;
  endfunction : slot_of

  // One-hot byte lane of a pointer address, zero when unmapped
  function automatic logic [2:0] lane_of(input logic [7:0] addr);
    logic [2:0] lane;
    lane = 3'h0;
    unique case (addr)
      `ADDR_PTR0_LOW, `ADDR_PTR1_LOW, `ADDR_PTR2_LOW, `ADDR_PTR3_LOW: lane = 3'h1; // RQ12 RQ13
      `ADDR_PTR0_MID, `ADDR_PTR1_MID, `ADDR_PTR2_MID, `ADDR_PTR3_MID: lane = 3'h2; // RQ12 RQ13
      `ADDR_PTR0_HIGH, `ADDR_PTR1_HIGH, `ADDR_PTR2_HIGH, `ADDR_PTR3_HIGH: lane = 3'h4; // RQ12 RQ13
      default: lane = 3'h0;
    endcase
    return lane;
  endfunction : lane_of

  quad_pointer_pkg::ctrl_type ctrl;
  quad_pointer_pkg::ctrl_type ctrl_next;
  logic [23:0] ptr_val [4];
  logic [23:0] ptr_next [4];
  logic [1:0] active_index;
  logic [1:0] active_index_next;
  logic [1:0] wr_slot;
  logic [2:0] wr_lane;
  logic [1:0] rd_slot;
  logic [2:0] rd_lane;
  logic ctrl_we;
  logic upper_we;
  logic toggle_event;
  logic step_event;
  logic [2:0] load_lanes;
  logic [7:0] rdata_next;
  logic hit_next;
  logic [23:0] rd_ptr;

  assign active_index = {ctrl.pointer_choice_msb, ctrl.pointer_choice_lsb}; // RQ2
  assign active_index_next = {ctrl_next.pointer_choice_msb, ctrl_next.pointer_choice_lsb};

  assign wr_slot = slot_of(sfr_req_in.addr);
  assign wr_lane = sfr_req_in.wr ? lane_of(sfr_req_in.addr) : 3'h0;
  assign rd_slot = slot_of(sfr_req_in.addr);
  assign rd_lane = lane_of(sfr_req_in.addr);
  assign ctrl_we = sfr_req_in.wr && (sfr_req_in.addr == `ADDR_CTRL);
  assign upper_we = sfr_req_in.wr && (sfr_req_in.addr == `ADDR_CTRL_UPPER);

  // Six instructions qualify for toggling, four for stepping (increment always, three only with auto-step)
  assign toggle_event = ctrl.auto_toggle_enable && (instr_in.inc_ptr || instr_in.load16 || instr_in.load24 ||
                        instr_in.code_read || instr_in.ext_read || instr_in.ext_write); // RQ7 RQ8
  assign step_event = instr_in.inc_ptr || (ctrl.auto_step_enable &&
                      (instr_in.code_read || instr_in.ext_read || instr_in.ext_write)); // RQ5 RQ9

  // A 16-bit load leaves the high byte alone
  assign load_lanes = instr_in.load24 ? 3'h7 : (instr_in.load16 ? 3'h3 : 3'h0);

  pointer_control_regs u_ctrl (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .ctrl_we_in(ctrl_we),
    .upper_we_in(upper_we),
    .wdata_in(sfr_req_in.wdata),
    .toggle_in(toggle_event),
    .ctrl_out(ctrl),
    .ctrl_next_out(ctrl_next)
  );

  // Step and load use the index held at the start of the instruction
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : slots
      logic is_active;
      assign is_active = (active_index == 2'(g)); // RQ3 RQ11
      pointer_slot u_slot (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .byte_we_in((wr_slot == 2'(g)) ? wr_lane : 3'h0),
        .wdata_in(sfr_req_in.wdata),
        .load_en_in(is_active ? load_lanes : 3'h0), // RQ3
        .load_data_in(load_data_in),
        .step_in(is_active && step_event), // RQ3 RQ11
        .down_in(ctrl.down_dir[g]), // RQ5 RQ6
        .ptr_out(ptr_val[g]),
        .ptr_next_out(ptr_next[g])
      );
    end
  endgenerate

  assign rd_ptr = ptr_val[rd_slot];

  always_comb begin
    rdata_next = 8'h00;
    hit_next = 1'b1;
    if (sfr_req_in.addr == `ADDR_CTRL) begin
      rdata_next[`BIT_CHOICE_LSB] = ctrl.pointer_choice_lsb;
      rdata_next[`BIT_CHOICE_MSB] = ctrl.pointer_choice_msb;
      rdata_next[`BIT_AUTO_STEP] = ctrl.auto_step_enable;
      rdata_next[`BIT_AUTO_TOGGLE] = ctrl.auto_toggle_enable;
      rdata_next[`BIT_DOWN_EVEN] = ctrl.down_dir[0];
      rdata_next[`BIT_DOWN_ODD] = ctrl.down_dir[1];
    end else if (sfr_req_in.addr == `ADDR_CTRL_UPPER) begin
      rdata_next[`BIT_DOWN_EVEN] = ctrl.down_dir[2];
      rdata_next[`BIT_DOWN_ODD] = ctrl.down_dir[3];
    end else if (rd_lane[0]) begin
      rdata_next = rd_ptr[7:0];
    end else if (rd_lane[1]) begin
      rdata_next = rd_ptr[15:8];
    end else if (rd_lane[2]) begin
      rdata_next = rd_ptr[23:16];
    end else begin
      hit_next = 1'b0;
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sfr_rdata_out <= 8'h00;
      sfr_hit_out <= 1'b0;
    end else if (sfr_req_in.rd) begin
      sfr_rdata_out <= rdata_next;
      sfr_hit_out <= hit_next;
    end
  end

  // Registered view of the pointer the next instruction will use
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      active_ptr_out <= `PTR_RESET;
      active_index_out <= 2'h0;
    end else begin
      active_ptr_out <= ptr_next[active_index_next]; // RQ3
      active_index_out <= active_index_next; // RQ2
    end
  end

endmodule : quad_data_pointer_unit

// ---- quad_pointer_defs.svh ----
// Constants for the quad data pointer unit
// Behaviour
// RQ1 - Four pointers, each 24 bits from high, middle and low byte registers.
// RQ2 - Control bits 3 and 0 pick pointer 0..3 as a two-bit number.
// RQ3 - Every pointer instruction acts on the pointer the select bits name.
// RQ4 - Control bits 2 and 1 unimplemented, so incrementing control flips only bit 0.
// RQ5 - Pointer increment adds one if direction bit clear, subtracts one if set.
// RQ6 - Direction bits: control bits 6,7 for pointers 0,1; upper control bits 6,7 for 2,3.
// RQ7 - Toggle enable at bit 5 inverts select bit 0 after qualifying instructions, bit 3 kept.
// RQ8 - Toggle applies to increment, both immediate loads, code read, external read and write.
// RQ9 - Auto-step at bit 4 steps pointer after code read and external read or write.
// RQ10 - No rotation through all four; toggle partners are fixed pairs only.
// RQ11 - Pointer active at instruction start is used and stepped, then select toggles.
// RQ12 - Pointer 0 at 93h, 83h, 82h; pointer 1 at 95h, 85h, 84h.
// RQ13 - Pointer 2 at EBh, F3h, F2h; pointer 3 at EDh, F5h, F4h.
// RQ14 - Steps carry across all 24 bits with wrap; control clears to zero on reset.
`ifndef QUAD_POINTER_DEFS_SVH
`define QUAD_POINTER_DEFS_SVH

`define ADDR_PTR0_HIGH 8'h93
`define ADDR_PTR0_MID 8'h83
`define ADDR_PTR0_LOW 8'h82
`define ADDR_PTR1_HIGH 8'h95
`define ADDR_PTR1_MID 8'h85
`define ADDR_PTR1_LOW 8'h84
`define ADDR_PTR2_HIGH 8'heb
`define ADDR_PTR2_MID 8'hf3
`define ADDR_PTR2_LOW 8'hf2
`define ADDR_PTR3_HIGH 8'hed
`define ADDR_PTR3_MID 8'hf5
`define ADDR_PTR3_LOW 8'hf4
`define ADDR_CTRL 8'h86
`define ADDR_CTRL_UPPER 8'he3

`define BIT_CHOICE_LSB 0
`define BIT_CHOICE_MSB 3
`define BIT_AUTO_STEP 4
`define BIT_AUTO_TOGGLE 5
`define BIT_DOWN_EVEN 6
`define BIT_DOWN_ODD 7

`define CTRL_RESET 8'h00
`define PTR_RESET 24'h000000
`define PTR_ONE 24'h000001

`endif

// ---- quad_pointer_pkg.sv ----
// Types shared by the quad data pointer unit
package quad_pointer_pkg;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  typedef struct packed {
    logic inc_ptr;
    logic load16;
    logic load24;
    logic code_read;
    logic ext_read;
    logic ext_write;
  } instr_strobe_type;

  typedef struct packed {
    logic [3:0] down_dir;
    logic auto_toggle_enable;
    logic auto_step_enable;
    logic pointer_choice_msb;
    logic pointer_choice_lsb;
  } ctrl_type;

endpackage : quad_pointer_pkg

// ---- pointer_slot.sv ----
// One 24-bit data pointer with byte writes, loads and steps
`timescale 1ns/1ns
`include "quad_pointer_defs.svh"
module pointer_slot (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [2:0] byte_we_in,
  input wire logic [7:0] wdata_in,
  input wire logic [2:0] load_en_in,
  input wire logic [23:0] load_data_in,
  input wire logic step_in,
  input wire logic down_in,
  output logic [23:0] ptr_out,
  output logic [23:0] ptr_next_out
);

  logic [23:0] ptr_reg;
  logic [23:0] ptr_next;
  logic [23:0] stepped;
  integer b;

  // Full 24-bit add or subtract, wraps modulo 2^24
  assign stepped = down_in ? ptr_reg - `PTR_ONE : ptr_reg + `PTR_ONE; // RQ5 RQ14

  always_comb begin
    ptr_next = step_in ? stepped : ptr_reg;
    for (b = 0; b < 3; b = b + 1) begin
      if (load_en_in[b]) begin
        ptr_next[b*8 +: 8] = load_data_in[b*8 +: 8];
      end
      // A direct byte write beats any step in the same cycle
      if (byte_we_in[b]) begin
        ptr_next[b*8 +: 8] = wdata_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ptr_reg <= `PTR_RESET;
    end else begin
      ptr_reg <= ptr_next; // RQ1
    end
  end

  assign ptr_out = ptr_reg;
  assign ptr_next_out = ptr_next;

endmodule : pointer_slot

// ---- pointer_control_regs.sv ----
// Pointer control and upper-pair control registers
`timescale 1ns/1ns
`include "quad_pointer_defs.svh"
module pointer_control_regs (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic ctrl_we_in,
  input wire logic upper_we_in,
  input wire logic [7:0] wdata_in,
  input wire logic toggle_in,
  output quad_pointer_pkg::ctrl_type ctrl_out,
  output quad_pointer_pkg::ctrl_type ctrl_next_out
);

  quad_pointer_pkg::ctrl_type ctrl_reg;
  quad_pointer_pkg::ctrl_type ctrl_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    // Only the low select bit flips, so toggling stays inside the pair
    if (toggle_in) begin
      ctrl_next.pointer_choice_lsb = ~ctrl_reg.pointer_choice_lsb; // RQ7 RQ10 RQ11
    end
    // Bits 2 and 1 have no storage; a carry out of bit 0 is simply lost
    if (ctrl_we_in) begin
      ctrl_next.pointer_choice_lsb = wdata_in[`BIT_CHOICE_LSB]; // RQ4
      ctrl_next.pointer_choice_msb = wdata_in[`BIT_CHOICE_MSB]; // RQ2
      ctrl_next.auto_step_enable = wdata_in[`BIT_AUTO_STEP];
      ctrl_next.auto_toggle_enable = wdata_in[`BIT_AUTO_TOGGLE];
      ctrl_next.down_dir[0] = wdata_in[`BIT_DOWN_EVEN]; // RQ6
      ctrl_next.down_dir[1] = wdata_in[`BIT_DOWN_ODD]; // RQ6
    end
    if (upper_we_in) begin
      ctrl_next.down_dir[2] = wdata_in[`BIT_DOWN_EVEN]; // RQ6
      ctrl_next.down_dir[3] = wdata_in[`BIT_DOWN_ODD]; // RQ6
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_reg <= quad_pointer_pkg::ctrl_type'(`CTRL_RESET); // RQ14
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign ctrl_out = ctrl_reg;
  assign ctrl_next_out = ctrl_next;

endmodule : pointer_control_regs

// ---- pointer_unit_asserts.sv ----
// Port checker for the quad data pointer unit
`timescale 1ns/1ns
`include "quad_pointer_defs.svh"
module pointer_unit_asserts (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input quad_pointer_pkg::sfr_req_type sfr_req_in,
  input quad_pointer_pkg::instr_strobe_type instr_in,
  input wire logic [23:0] load_data_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic sfr_hit_out,
  input wire logic [23:0] active_ptr_out,
  input wire logic [1:0] active_index_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire logic mapped = sfr_req_in.addr inside {`ADDR_PTR0_HIGH, `ADDR_PTR0_MID, `ADDR_PTR0_LOW, `ADDR_PTR1_HIGH,
    `ADDR_PTR1_MID, `ADDR_PTR1_LOW, `ADDR_PTR2_HIGH, `ADDR_PTR2_MID, `ADDR_PTR2_LOW, `ADDR_PTR3_HIGH,
    `ADDR_PTR3_MID, `ADDR_PTR3_LOW, `ADDR_CTRL, `ADDR_CTRL_UPPER};
  sequence instr_alone; (|instr_in) && !sfr_req_in.wr; endsequence
  sequence load24_alone; instr_in.load24 && !sfr_req_in.wr; endsequence
  sequence load16_alone; instr_in.load16 && !sfr_req_in.wr; endsequence
  sequence inc_alone; instr_in.inc_ptr && !sfr_req_in.wr; endsequence
  sequence data_alone; (instr_in.code_read || instr_in.ext_read || instr_in.ext_write) && !sfr_req_in.wr; endsequence
  read_held_a: assert property (!sfr_req_in.rd |=> $stable(sfr_rdata_out) && $stable(sfr_hit_out))
    else $error("read result changed without a read");
  mapped_hit_a: assert property (sfr_req_in.rd && mapped |=> sfr_hit_out)
    else $error("mapped read not flagged");
  unmapped_zero_a: assert property (sfr_req_in.rd && !mapped |=> !sfr_hit_out && sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  pair_fixed_a: assert property (instr_alone |=> active_index_out[1] == $past(active_index_out[1]))
    else $error("toggle left its pair");
  idle_stable_a: assert property (!(|instr_in) && !sfr_req_in.wr |=>
    $stable(active_ptr_out) && $stable(active_index_out)) else $error("pointer moved while idle");
  load24_value_a: assert property (load24_alone |=> active_index_out != $past(active_index_out)
    || active_ptr_out == $past(load_data_in)) else $error("wide load value wrong");
  load16_value_a: assert property (load16_alone |=> active_index_out != $past(active_index_out)
    || active_ptr_out == {$past(active_ptr_out[23:16]), $past(load_data_in[15:0])})
    else $error("short load wrong");
  inc_step_a: assert property (inc_alone |=> active_index_out != $past(active_index_out)
    || active_ptr_out == $past(active_ptr_out) + 24'h000001 || active_ptr_out == $past(active_ptr_out) - 24'h000001)
    else $error("increment did not step by one");
  data_step_a: assert property (data_alone |=> active_index_out != $past(active_index_out)
    || $stable(active_ptr_out) || active_ptr_out == $past(active_ptr_out) + 24'h000001
    || active_ptr_out == $past(active_ptr_out) - 24'h000001)
    else $error("data access stepped wrongly");
endmodule : pointer_unit_asserts
bind quad_data_pointer_unit pointer_unit_asserts u_pointer_unit_asserts (.ref_clk_in, .arst_n_in, .sfr_req_in,
  .instr_in, .load_data_in, .sfr_rdata_out, .sfr_hit_out, .active_ptr_out, .active_index_out);

// ---- cpu_issue_model.sv ----
// CPU side model: one register access or one pointer instruction per cycle
`timescale 1ns/1ns
module cpu_issue_model (
  input wire logic [3:0] op_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output quad_pointer_pkg::sfr_req_type sfr_req_out,
  output quad_pointer_pkg::instr_strobe_type instr_out
);
  // Codes 3..8 map to one strobe each, so two instructions never share a cycle
  always_comb begin
    sfr_req_out = '{rd: op_in == 4'h2, wr: op_in == 4'h1, addr: addr_in, wdata: wdata_in};
    instr_out = quad_pointer_pkg::instr_strobe_type'((op_in > 4'h2 && op_in < 4'h9) ?
      6'h20 >> (op_in - 4'h3) : 6'h00);
  end
endmodule : cpu_issue_model

// ---- testbench.sv ----
// Self-checking bench for the quad data pointer unit
`timescale 1ns/1ns
`include "quad_pointer_defs.svh"
module testbench;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] op = 4'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [23:0] load_data = 24'h000000;
  quad_pointer_pkg::sfr_req_type sfr_req;
  quad_pointer_pkg::instr_strobe_type instr;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic [23:0] active_ptr;
  logic [1:0] active_index;
  logic [23:0] ptr [4] = '{default: 24'h000000};
  logic [7:0] ctrl = 8'h00;
  logic [7:0] upper = 8'h00;
  logic [26:0] notes [$];
  int miscompares = 0;
  int samples_checked = 0;
  logic [7:0] map [14] = '{`ADDR_PTR0_LOW, `ADDR_PTR0_MID, `ADDR_PTR0_HIGH, `ADDR_PTR1_LOW, `ADDR_PTR1_MID,
    `ADDR_PTR1_HIGH, `ADDR_PTR2_LOW, `ADDR_PTR2_MID, `ADDR_PTR2_HIGH, `ADDR_PTR3_LOW, `ADDR_PTR3_MID,
    `ADDR_PTR3_HIGH, `ADDR_CTRL, `ADDR_CTRL_UPPER};
  always #10 ref_clk_in = ~ref_clk_in;
  cpu_issue_model u_cpu_issue_model (.op_in(op), .addr_in(addr), .wdata_in(wdata), .sfr_req_out(sfr_req),
    .instr_out(instr));
  quad_data_pointer_unit u_quad_data_pointer_unit (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .sfr_req_in(sfr_req), .instr_in(instr), .load_data_in(load_data), .sfr_rdata_out(sfr_rdata),
    .sfr_hit_out(sfr_hit), .active_ptr_out(active_ptr), .active_index_out(active_index));
  task automatic cmp_ptr(input logic [25:0] exp, input logic [25:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED active pointer expected %h seen %h", exp, got);
    end
  endtask : cmp_ptr
  task automatic cmp_read(input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED read hit and data expected %h seen %h", exp, got);
    end
  endtask : cmp_read
  function automatic logic [8:0] rd_exp(input logic [7:0] a);
    for (int k = 0; k < 12; k++) if (map[k] == a) return {1'b1, ptr[k / 3][8 * (k % 3) +: 8]};
    if (a == map[12]) return {1'b1, ctrl};
    if (a == map[13]) return {1'b1, upper};
    return 9'h000;
  endfunction : rd_exp
  // Expectation is noted as the request is driven; the watcher pops it one edge later
  task automatic do_op(input logic [3:0] o, input logic [7:0] a, input logic [7:0] d, input logic [23:0] ld);
    logic [1:0] s;
    logic dn;
    @(posedge ref_clk_in);
    #1;
    op = o;
    addr = a;
    wdata = d;
    load_data = ld;
    s = {ctrl[3], ctrl[0]};
    dn = s[1] ? upper[6 + s[0]] : ctrl[6 + s[0]];
    if (o == 4'h2) notes.push_back({1'b1, 17'h00000, rd_exp(a)});
    else if (o != 4'h0) begin
      if (o == 4'h1) begin
        for (int k = 0; k < 12; k++) if (map[k] == a) ptr[k / 3][8 * (k % 3) +: 8] = d;
        if (a == map[12]) ctrl = d & 8'hf9;
        if (a == map[13]) upper = d & 8'hc0;
      end
      if (o == 4'h3 || (o > 4'h5 && ctrl[4])) ptr[s] = dn ? ptr[s] - 24'h000001 : ptr[s] + 24'h000001;
      if (o == 4'h4) ptr[s][15:0] = ld[15:0];
      if (o == 4'h5) ptr[s] = ld;
      if (o > 4'h2 && ctrl[5]) ctrl[0] = ~ctrl[0];
      notes.push_back({1'b0, ctrl[3], ctrl[0], ptr[{ctrl[3], ctrl[0]}]});
    end
  endtask : do_op
  always @(posedge ref_clk_in) begin : watch
    logic [26:0] n;
    if (op != 4'h0) begin
      #2;
      n = notes.pop_front();
      if (n[26]) cmp_read(n[8:0], {sfr_hit, sfr_rdata});
      else cmp_ptr(n[25:0], {active_index, active_ptr});
    end
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    void'($urandom(15005));
    repeat (5) @(posedge ref_clk_in);
    #1 arst_n_in = 1'b1;
    do_op(4'h2, map[12], 8'h00, 24'h000000);
    for (int k = 0; k < 14; k++) do_op(4'h1, map[k], 8'($urandom), 24'h000000);
    for (int k = 0; k < 14; k++) do_op(4'h2, map[k], 8'h00, 24'h000000);
    do_op(4'h2, 8'h81, 8'h00, 24'h000000);
    // Wrap in both directions on pointer 0
    do_op(4'h1, map[12], 8'h00, 24'h000000);
    do_op(4'h5, 8'h00, 8'h00, 24'hffffff);
    do_op(4'h3, 8'h00, 8'h00, 24'h000000);
    do_op(4'h1, map[12], 8'h40, 24'h000000);
    do_op(4'h3, 8'h00, 8'h00, 24'h000000);
    repeat (1500) do_op(4'(1 + $urandom % 8), $urandom % 2 ? map[12 + $urandom % 2] : map[$urandom % 14],
      8'($urandom), 24'($urandom));
    do_op(4'h0, 8'h00, 8'h00, 24'h000000);
    do_op(4'h0, 8'h00, 8'h00, 24'h000000);
    final_report();
  end
endmodule : testbench
